// ### rtl/optical_port_output_conditioner.sv
`include "optical_cfg.svh"

module optical_port_output_conditioner #(
    parameter int CARRIER_PERIOD = `OPT_CARRIER_PERIOD,
    parameter int CNT_W = `OPT_CARRIER_CNT_W
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Register bus.
    input wire optical_pkg::avmm_req_s avmm_req_i,
    output optical_pkg::avmm_rsp_s avmm_rsp_o,
    // UART side.
    input wire logic uart_tx_i,
    output logic uart_rx_o,
    // Power state.
    input wire logic brownout_i,
    // Pins.
    input wire logic optical_rx_pin_i,
    output logic optical_tx_pin_o,
    output logic optical_tx_pin_oe_o
);
    import optical_pkg::*;

    localparam int LAST_GAP = CARRIER_PERIOD - 1;

    logic [`OPT_CTRL_MSB:0] ctrl_r;
    opt_ctrl_s ctrl;
    logic bo_meta_r;
    logic bo_sync_r;
    logic rx_meta_r;
    logic rx_sync_r;
    logic carrier_low;
    logic carrier_wrap;
    logic mod_active;
    logic tx_shaped;
    logic tx_pin_r;
    logic tx_oe_r;
    logic uart_rx_r;
    logic wait_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic req;
    logic accept;
    logic [`OPT_STAT_MOD_BIT:0] status;

    assign ctrl = opt_ctrl_s'(ctrl_r);
    assign req = avmm_req_i.read || avmm_req_i.write;
    // A request completes in the cycle where waitrequest is low.
    assign accept = req && !wait_r;

    // Pins and the power flag come from outside, so two stages each.
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            bo_meta_r <= 1'b0;
            bo_sync_r <= 1'b0;
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
        end
        else
        begin
            bo_meta_r <= brownout_i;
            bo_sync_r <= bo_meta_r;
            rx_meta_r <= optical_rx_pin_i;
            rx_sync_r <= rx_meta_r;
        end
    end

    // One wait state: it lets read data settle in a flop first.
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            wait_r <= 1'b1;
        else if (req && wait_r)
            wait_r <= 1'b0;
        else
            wait_r <= 1'b1;
    end

    // Control register; only byte lane 0 carries fields.
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            ctrl_r <= `OPT_CTRL_RESET;
        else if (accept && avmm_req_i.write &&
                 avmm_req_i.address == `OPT_CTRL_ADDR &&
                 avmm_req_i.byteenable[0])
            ctrl_r <= avmm_req_i.writedata[`OPT_CTRL_MSB:0];
    end

    // Live status bits.
    assign status[`OPT_STAT_BO_BIT] = bo_sync_r;
    assign status[`OPT_STAT_RX_BIT] = rx_sync_r;
    assign status[`OPT_STAT_TX_BIT] = tx_pin_r;
    assign status[`OPT_STAT_CAR_BIT] = carrier_low;
    assign status[`OPT_STAT_MOD_BIT] = mod_active;

    // Read mux; unmapped addresses read as zero.
    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        case (avmm_req_i.address)
            `OPT_CTRL_ADDR: rdata_nxt[`OPT_CTRL_MSB:0] = ctrl_r;
            `OPT_STAT_ADDR: rdata_nxt[`OPT_STAT_MOD_BIT:0] = status;
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // Read data is captured during the wait state and held after.
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rdata_r <= 32'h0000_0000;
        else if (avmm_req_i.read && wait_r)
            rdata_r <= rdata_nxt;
    end

    assign avmm_rsp_o.readdata = rdata_r;
    assign avmm_rsp_o.waitrequest = wait_r;

    // Carrier runs only while enabled and not in brownout, whatever the pin select.
    assign mod_active = ctrl.carrier_enable && !bo_sync_r;

    carrier_gen #(
        .PERIOD(CARRIER_PERIOD),
        .CNT_W(CNT_W)
    ) u_carrier (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .enable_i(mod_active),
        .duty_i(ctrl.carrier_duty_select),
        .low_o(carrier_low),
        .wrap_o(carrier_wrap)
    );

    // A low data bit becomes carrier bursts; high stays idle high.
    always_comb
    begin
        if (mod_active && !uart_tx_i)
            tx_shaped = !carrier_low;
        else
            tx_shaped = uart_tx_i;
    end

    // Transmit pin value, inverted after shaping, and its enable.
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            tx_pin_r <= 1'b1;
            tx_oe_r <= 1'b0;
        end
        else
        begin
            tx_pin_r <= tx_shaped ^ ctrl.tx_invert;
            tx_oe_r <= (ctrl.tx_pin_select == `OPT_SEL_ACTIVE);
        end
    end

    // Receive path toward the UART.
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            uart_rx_r <= 1'b1;
        else
            uart_rx_r <= rx_sync_r ^ ctrl.rx_invert;
    end

    assign optical_tx_pin_o = tx_pin_r;
    assign optical_tx_pin_oe_o = tx_oe_r;
    assign uart_rx_o = uart_rx_r;

    // Helper logic for the checks below: period and low-time counts.
    logic [CNT_W-1:0] gap_r;
    logic [CNT_W-1:0] low_run_r;
    logic seen_wrap_r;
    logic duty_chg_r;
    logic [CNT_W-1:0] low_expect;

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            gap_r <= '0;
            low_run_r <= '0;
            seen_wrap_r <= 1'b0;
            duty_chg_r <= 1'b0;
        end
        else if (!mod_active)
        begin
            gap_r <= '0;
            low_run_r <= '0;
            seen_wrap_r <= 1'b0;
            duty_chg_r <= 1'b0;
        end
        else if (carrier_wrap)
        begin
            gap_r <= '0;
            low_run_r <= '0;
            seen_wrap_r <= 1'b1;
            duty_chg_r <= 1'b0;
        end
        else
        begin
            gap_r <= gap_r + CNT_W'(1);
            if (carrier_low)
                low_run_r <= low_run_r + CNT_W'(1);
            if ($changed(ctrl.carrier_duty_select))
                duty_chg_r <= 1'b1;
        end
    end

    always_comb
    begin
        case (ctrl.carrier_duty_select)
            `OPT_DUTY_50: low_expect = CNT_W'(CARRIER_PERIOD / 2);
            `OPT_DUTY_25: low_expect = CNT_W'(CARRIER_PERIOD / 4);
            `OPT_DUTY_12: low_expect = CNT_W'(CARRIER_PERIOD / 8);
            `OPT_DUTY_6: low_expect = CNT_W'(CARRIER_PERIOD / 16);
            default: low_expect = '0;
        endcase
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);

    AST_PIN_DRIVEN: assert property (
        ctrl.tx_pin_select == `OPT_SEL_ACTIVE |=> optical_tx_pin_oe_o)
        else $error("Transmit pin not driven with select 00.");

    AST_PIN_RELEASED: assert property (
        ctrl.tx_pin_select != `OPT_SEL_ACTIVE |=> !optical_tx_pin_oe_o)
        else $error("Transmit pin driven in alternate role.");

    AST_TX_POLARITY: assert property (
        !mod_active |=>
        optical_tx_pin_o == ($past(uart_tx_i) ^ $past(ctrl.tx_invert)))
        else $error("Transmit polarity wrong without carrier.");

    AST_RX_POLARITY: assert property (
        $stable(ctrl.rx_invert) |->
        uart_rx_o == ($past(optical_rx_pin_i, 3) ^ $past(ctrl.rx_invert)))
        else $error("Receive polarity or latency wrong.");

    AST_CARRIER_PERIOD: assert property (
        carrier_wrap && seen_wrap_r |-> gap_r == CNT_W'(LAST_GAP))
        else $error("Carrier period is not the expected count.");

    AST_NO_MOD_BROWNOUT: assert property (
        bo_sync_r |-> !mod_active ##1
        optical_tx_pin_o == ($past(uart_tx_i) ^ $past(ctrl.tx_invert)))
        else $error("Carrier applied during brownout.");

    AST_NO_MOD_DISABLED: assert property (
        !ctrl.carrier_enable [*2] |-> !carrier_low && !carrier_wrap)
        else $error("Carrier runs while modulation is off.");

    AST_MOD_GATES: assert property (
        mod_active && !uart_tx_i |=>
        optical_tx_pin_o == (!$past(carrier_low) ^ $past(ctrl.tx_invert)))
        else $error("Low data bit not gated by carrier.");

    AST_LOW_TIME: assert property (
        carrier_wrap && seen_wrap_r && !duty_chg_r &&
        $stable(ctrl.carrier_duty_select) |-> low_run_r == low_expect)
        else $error("Carrier low time does not match duty.");

    AST_DUTY_START: assert property (
        $rose(mod_active) |-> carrier_low)
        else $error("Carrier burst does not start low.");

    AST_BUS_ONE_WAIT: assert property (
        req && avmm_rsp_o.waitrequest |=> !avmm_rsp_o.waitrequest
        ##1 avmm_rsp_o.waitrequest)
        else $error("Bus answer not after exactly one wait state.");

    COV_SMALL_DUTY: cover property (
        mod_active && ctrl.carrier_duty_select == `OPT_DUTY_6 &&
        carrier_wrap && seen_wrap_r);

    COV_BROWNOUT_ENABLED: cover property (
        ctrl.carrier_enable && $rose(bo_sync_r));

    COV_RX_INVERTED: cover property (
        ctrl.rx_invert && $fell(uart_rx_o));

    COV_ALT_ROLE: cover property ($fell(optical_tx_pin_oe_o));

endmodule // optical_port_output_conditioner

// ### rtl/optical_cfg.svh
// How it works
// - Transmit pin driven only when select is 00.
// - Transmit and receive polarity inverted independently.
// - Enabled modulation gates transmit with 38 kHz carrier.
// - No carrier while in brownout mode.
// - Carrier applied only while modulation enable set.
// - Duty select offers 50, 25, 12.5, 6.25 percent.
// - Duty figure is the low fraction per period.
`ifndef OPTICAL_CFG_SVH
`define OPTICAL_CFG_SVH

// System clock rate and carrier frequency in hertz.
`define OPT_CLK_HZ 25000000
`define OPT_CARRIER_HZ 38000
// Carrier period in clock cycles, rounded to the nearest cycle.
`define OPT_CARRIER_PERIOD \
    ((`OPT_CLK_HZ + (`OPT_CARRIER_HZ / 2)) / `OPT_CARRIER_HZ)
`define OPT_CARRIER_CNT_W 10

// Byte addresses of the two registers.
`define OPT_CTRL_ADDR 4'h0
`define OPT_STAT_ADDR 4'h4

// Control register layout and reset value.
`define OPT_CTRL_MSB 6
`define OPT_CTRL_RESET 7'h01
`define OPT_SEL_LSB 0
`define OPT_SEL_MSB 1
`define TX_INVERT_BIT 2
`define RX_INVERT_BIT 3
`define OPT_CEN_BIT 4
`define OPT_DUTY_LSB 5
`define OPT_DUTY_MSB 6
`define OPT_SEL_ACTIVE 2'h0

// Duty select codes.
`define OPT_DUTY_50 2'h0
`define OPT_DUTY_25 2'h1
`define OPT_DUTY_12 2'h2
`define OPT_DUTY_6 2'h3

// Status register layout.
`define OPT_STAT_BO_BIT 0
`define OPT_STAT_RX_BIT 1
`define OPT_STAT_TX_BIT 2
`define OPT_STAT_CAR_BIT 3
`define OPT_STAT_MOD_BIT 4

`endif

// ### rtl/optical_pkg.sv
package optical_pkg;

    // Avalon-MM request from the master.
    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avmm_req_s;

    // Avalon-MM answer to the master.
    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } avmm_rsp_s;

    // Control register fields, msb first.
    typedef struct packed {
        logic [1:0] carrier_duty_select;
        logic carrier_enable;
        logic rx_invert;
        logic tx_invert;
        logic [1:0] tx_pin_select;
    } opt_ctrl_s;

endpackage

// ### rtl/carrier_gen.sv
`include "optical_cfg.svh"

module carrier_gen #(
    parameter int PERIOD = `OPT_CARRIER_PERIOD,
    parameter int CNT_W = `OPT_CARRIER_CNT_W
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Control.
    input wire logic enable_i,
    input wire logic [1:0] duty_i,
    // Carrier phase.
    output logic low_o,
    output logic wrap_o
);

    localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD - 1);
    localparam logic [CNT_W-1:0] LOW50 = CNT_W'(PERIOD / 2);
    localparam logic [CNT_W-1:0] LOW25 = CNT_W'(PERIOD / 4);
    localparam logic [CNT_W-1:0] LOW12 = CNT_W'(PERIOD / 8);
    localparam logic [CNT_W-1:0] LOW6 = CNT_W'(PERIOD / 16);

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] low_lim;

    // Phase counter; held at zero while idle so each burst starts low.
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            cnt_r <= '0;
        else if (!enable_i || cnt_r == LAST)
            cnt_r <= '0;
        else
            cnt_r <= cnt_r + CNT_W'(1);
    end

    // Low time per period from the duty code.
    always_comb
    begin
        case (duty_i)
            `OPT_DUTY_50: low_lim = LOW50;
            `OPT_DUTY_25: low_lim = LOW25;
            `OPT_DUTY_12: low_lim = LOW12;
            `OPT_DUTY_6: low_lim = LOW6;
            default: low_lim = LOW50;
        endcase
    end

    // Low during the first part of each period.
    assign low_o = enable_i && (cnt_r < low_lim);
    assign wrap_o = enable_i && (cnt_r == LAST);

endmodule // carrier_gen

// ### testbench/optical_link_model.sv
module optical_link_model (
    // Emitter side.
    input wire logic tx_pin_i,
    input wire logic tx_oe_i,
    // Phototransistor side.
    input wire logic light_i,
    output logic rx_pin_o,
    output logic wire_o
);
    // A released pin rests at the pull-up level, never at its last value.
    assign wire_o = tx_oe_i ? tx_pin_i : 1'b1;
    // Incoming light reaches the receive pin at once; the bench changes it
    // only after a clock edge, so no edge sees a half-settled level.
    assign rx_pin_o = light_i;
endmodule // optical_link_model

// ### testbench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import optical_pkg::*;

    logic mclk_i = 1'b0;
    logic resetn_i;
    avmm_req_s req;
    avmm_rsp_s rsp;
    logic uart_tx, uart_rx, brownout, light, rx_pin, tx_pin, tx_oe, wire_lvl;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    logic [31:0] rnd;
    logic [31:0] expq[$];

    // A short carrier keeps the run brief; low counts are 16, 8, 4 and 2.
    optical_port_output_conditioner #(.CARRIER_PERIOD(32), .CNT_W(10))
        u_optical_port_output_conditioner (.mclk_i(mclk_i),
        .resetn_i(resetn_i), .avmm_req_i(req), .avmm_rsp_o(rsp),
        .uart_tx_i(uart_tx), .uart_rx_o(uart_rx), .brownout_i(brownout),
        .optical_rx_pin_i(rx_pin), .optical_tx_pin_o(tx_pin),
        .optical_tx_pin_oe_o(tx_oe));

    optical_link_model u_optical_link_model (
        .tx_pin_i(tx_pin), .tx_oe_i(tx_oe), .light_i(light),
        .rx_pin_o(rx_pin), .wire_o(wire_lvl));

    // The clock toggles every 20 ns, a period of 40 ns.
    always #20 mclk_i = ~mclk_i;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // The request is held until an edge samples waitrequest low.
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        @(posedge mclk_i);
        req <= '{!wr, wr, a, d, be};
        do @(negedge mclk_i); while (rsp.waitrequest !== 1'b0);
        @(posedge mclk_i);
        req <= '0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        expq.push_back(exp);
        bus(1'b0, a, 32'h0, 4'hF);
    endtask

    // Low cycles of the pin over exactly one carrier period, any phase.
    task automatic count_low(input logic [31:0] exp);
        int n;
        n = 0;
        repeat (32)
        begin
            @(negedge mclk_i);
            if (wire_lvl === 1'b0)
                n++;
        end
        chk("low cycles", exp, n);
    endtask

    // Read data is compared with the oldest note in the cycle it stands.
    always @(negedge mclk_i)
        if (req.read === 1'b1 && rsp.waitrequest === 1'b0)
        begin
            if (expq.size() == 0)
                chk("unexpected read", 32'h0, 32'h1);
            else
                chk("readdata", expq.pop_front(), rsp.readdata);
        end

    // A hang would otherwise stall the run; the ceiling is far above need.
    always @(posedge mclk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            close_out();
        end
    end

    // Main sequence.
    initial
    begin
        req = '0;
        uart_tx = 1'b1;
        brownout = 1'b0;
        light = 1'b1;
        resetn_i = 1'b0;
        rnd = 32'hBAC0EFAF;
        repeat (5) @(posedge mclk_i);
        resetn_i <= 1'b1;
        rd(4'h0, 32'h01);
        chk("oe", 32'h0, {31'h0, tx_oe});
        bus(1'b1, 4'h0, 32'h00, 4'h0);
        rd(4'h0, 32'h01);
        bus(1'b1, 4'h0, 32'h00, 4'hF);
        rd(4'h0, 32'h00);
        rd(4'h8, 32'h00);
        chk("oe", 32'h1, {31'h0, tx_oe});
        $display("test registers done");
        for (int i = 0; i < 16; i++)
        begin
            rnd = lfsr(rnd);
            bus(1'b1, 4'h0, {28'h0, rnd[3:2], 2'b00}, 4'hF);
            uart_tx <= rnd[4];
            light <= rnd[5];
            repeat (4) @(posedge mclk_i);
            @(negedge mclk_i);
            chk("tx pin", {31'h0, rnd[4] ^ rnd[2]}, {31'h0, tx_pin});
            chk("uart rx", {31'h0, rnd[5] ^ rnd[3]}, {31'h0, uart_rx});
        end
        $display("test polarity done");
        for (int k = 0; k < 8; k++)
        begin
            bus(1'b1, 4'h0, {25'h0, k[1:0], 1'b1, 1'b0, k[2], 2'b00}, 4'hF);
            uart_tx <= 1'b0;
            repeat (4) @(posedge mclk_i);
            count_low(k[2] ? 32 - (16 >> k[1:0]) : 16 >> k[1:0]);
        end
        $display("test duty done");
        bus(1'b1, 4'h0, 32'h10, 4'hF);
        brownout <= 1'b1;
        repeat (6) @(posedge mclk_i);
        count_low(32);
        // Status shows the synced flag with modulation held off.
        rd(4'h4, {27'h0, 3'b000, light, 1'b1});
        brownout <= 1'b0;
        repeat (6) @(posedge mclk_i);
        count_low(16);
        bus(1'b1, 4'h0, 32'h00, 4'hF);
        repeat (4) @(posedge mclk_i);
        count_low(32);
        bus(1'b1, 4'h0, 32'h11, 4'hF);
        repeat (4) @(posedge mclk_i);
        count_low(0);
        chk("oe", 32'h0, {31'h0, tx_oe});
        $display("test power and release done");
        close_out();
    end
endmodule // tb
